// ===== tb/flash_protect_and_ext_address_tb.sv
`timescale 1ns/1ps

module flash_protect_and_ext_address_tb;
  import flash_protect_pkg::*;

  logic          core_clk, reset, spi_sclk, spi_cs_n, spi_di, hw_reset_pin_n, soft_reset_req;
  logic          scheme, compl, topbot, pum, ext_wr_en, lock_wr_en, lock_wr_value, lock_all_en, lock_all_value;
  logic [3:0]    bp;
  logic [7:0]    ext_wr_data;
  block_idx_type lock_wr_block;
  logic          current_addr_mode, addr_valid, op_accept, op_refuse;
  logic [7:0]    ext_addr_byte, target_opcode;
  logic [24:0]   target_addr, last_addr;
  int            n_fail, check_count, n_valid, n_acc, n_ref, cycles;
  logic [14:0]   corner [9];
  logic [7:0]    wr_opc [4];
  block_idx_type blk;
  logic [31:0]   a;

  flash_protect_and_ext_address DUT (
    .core_clk(core_clk), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_di(spi_di),
    .hw_reset_pin_n(hw_reset_pin_n), .soft_reset_req(soft_reset_req), .protect_scheme_select(scheme),
    .protect_complement(compl), .top_bottom_select(topbot), .block_protect_bit3(bp[3]),
    .block_protect_bit2(bp[2]), .block_protect_bit1(bp[1]), .block_protect_bit0(bp[0]),
    .power_up_addr_mode(pum), .ext_addr_wr_en(ext_wr_en), .ext_addr_wr_data(ext_wr_data),
    .lock_wr_en(lock_wr_en), .lock_wr_block(lock_wr_block), .lock_wr_value(lock_wr_value),
    .lock_all_en(lock_all_en), .lock_all_value(lock_all_value), .current_addr_mode(current_addr_mode),
    .ext_addr_byte(ext_addr_byte), .addr_valid(addr_valid), .target_addr(target_addr),
    .target_opcode(target_opcode), .op_accept(op_accept), .op_refuse(op_refuse)
  );

  spi_host_model model (
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_di  (spi_di)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Pulse monitor and hang guard
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (addr_valid === 1'b1) begin
      n_valid++;
      last_addr = target_addr;
    end
    if (op_accept === 1'b1) n_acc++;
    if (op_refuse === 1'b1) n_ref++;
    if (cycles == 60000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Protected state of one block under the code scheme, worked out from the table
  function automatic logic prot0(block_idx_type b, logic c, logic t, logic [3:0] code);
    int   n;
    logic p;
    if (code == 4'h0) p = 1'b0;
    else if (code >= 4'ha) p = 1'b1;
    else begin
      n = 1 << (code - 1);
      p = t ? (int'(b) < n) : (int'(b) >= 512 - n);
    end
    return p ^ c;
  endfunction

  task automatic op(input logic [7:0] opc, input logic [31:0] addr, input int nab, input int extra);
    n_valid = 0;
    n_acc   = 0;
    n_ref   = 0;
    model.frame(opc, addr, nab, extra);
    step(8);
  endtask

  task automatic write_op(input logic [7:0] opc, input logic [31:0] addr, input int nab, input logic acc,
                          input logic [24:0] exp_addr);
    op(opc, addr, nab, 0);
    check("addr_valid count", 32'(n_valid), 32'h1);
    check("target_opcode", 32'(target_opcode), 32'(opc));
    check("target_addr", 32'(last_addr), 32'(exp_addr));
    check("op_accept count", 32'(n_acc), 32'(acc));
    check("op_refuse count", 32'(n_ref), 32'(!acc));
  endtask

  task automatic set_ext(input logic [7:0] d);
    ext_wr_en   = 1'b1;
    ext_wr_data = d;
    step(1);
    ext_wr_en = 1'b0;
    step(1);
  endtask

  task automatic set_prot(input logic s, input logic c, input logic t, input logic [3:0] code);
    scheme = s;
    compl  = c;
    topbot = t;
    bp     = code;
  endtask

  initial begin
    {reset, soft_reset_req, scheme, compl, topbot, pum, ext_wr_en, lock_wr_en} = 8'hff;
    {soft_reset_req, scheme, compl, topbot, pum, ext_wr_en, lock_wr_en} = 7'h00;
    {lock_wr_value, lock_all_en, lock_all_value, bp, ext_wr_data, lock_wr_block} = '0;
    hw_reset_pin_n = 1'b1;
    n_fail = 0;
    check_count = 0;
    cycles = 0;
    void'($urandom(77359));
    // Format: complement, top/bottom, code, block
    corner = '{{1'b1, 1'b0, 4'h1, 9'd511}, {1'b1, 1'b0, 4'h1, 9'd510}, {1'b1, 1'b1, 4'h1, 9'd0},
               {1'b1, 1'b1, 4'h1, 9'd1}, {1'b1, 1'b0, 4'h0, 9'd77}, {1'b1, 1'b0, 4'hc, 9'd5},
               {1'b1, 1'b1, 4'ha, 9'd300}, {1'b0, 1'b0, 4'h9, 9'd256}, {1'b0, 1'b0, 4'h9, 9'd255}};
    wr_opc = '{8'h02, 8'h20, 8'h52, 8'hd8};
    step(10);
    reset = 1'b0;
    step(6);
    check("ext after power-up", 32'(ext_addr_byte), 32'h0);
    check("mode after power-up", 32'(current_addr_mode), 32'h0);
    for (int i = 0; i < 24; i++) begin
      if (i < 9) {compl, topbot, bp, blk} = corner[i];
      else {compl, topbot, bp, blk} = 15'($urandom);
      scheme = 1'b0;
      set_ext({7'($urandom), blk[8]});
      a = {8'h00, blk[7:0], 16'($urandom)};
      write_op(wr_opc[i % 4], a, 3, !prot0(blk, compl, topbot, bp), {blk, a[15:0]});
    end
    set_prot(1'b0, 1'b1, 1'b0, 4'hc);
    op(8'h20, 32'h0, 3, 3);
    check("partial byte accept/refuse", 32'(n_acc + n_ref), 32'h0);
    op(8'hc7, 32'h0, 0, 0);
    check("chip erase open", 32'(n_acc), 32'h1);
    set_prot(1'b0, 1'b0, 1'b0, 4'h1);
    op(8'h60, 32'h0, 0, 0);
    check("chip erase protected", 32'(n_ref), 32'h1);
    set_prot(1'b1, 1'b1, 1'b0, 4'hc);
    set_ext(8'h00);
    write_op(8'hd8, 32'h00070000, 3, 1'b0, 25'h0070000);
    lock_wr_block = 9'd7;
    lock_wr_en    = 1'b1;
    step(1);
    lock_wr_en = 1'b0;
    step(1);
    write_op(8'hd8, 32'h00070000, 3, 1'b1, 25'h0070000);
    write_op(8'h02, 32'h00080000, 3, 1'b0, 25'h0080000);
    // Scheme zero with nothing protected while block 8 is still locked
    set_prot(1'b0, 1'b0, 1'b0, 4'h0);
    write_op(8'h02, 32'h00080000, 3, 1'b1, 25'h0080000);
    scheme       = 1'b1;
    lock_all_en  = 1'b1;
    step(1);
    lock_all_en = 1'b0;
    write_op(8'h20, 32'h00080000, 3, 1'b1, 25'h0080000);
    lock_wr_block = 9'd8;
    lock_wr_value = 1'b1;
    lock_wr_en    = 1'b1;
    step(1);
    lock_wr_en = 1'b0;
    write_op(8'hdc, 32'h4e080000, 4, 1'b0, 25'h0080000);
    check("ext after 4-byte erase", 32'(ext_addr_byte), 32'h4e);
    set_ext(8'h3d);
    soft_reset_req = 1'b1;
    step(1);
    soft_reset_req = 1'b0;
    step(6);
    check("ext after soft reset", 32'(ext_addr_byte), 32'h0);
    write_op(8'h20, 32'h00080000, 3, 1'b0, 25'h0080000);
    scheme = 1'b0;
    a = {8'h5b, 24'($urandom)};
    write_op(8'h21, a, 4, 1'b1, a[24:0]);
    check("ext after 4-byte op", 32'(ext_addr_byte), 32'h5b);
    a = {8'h6c, 24'($urandom)};
    op(8'h13, a, 4, 8);
    check("read addr_valid count", 32'(n_valid), 32'h1);
    check("read accept/refuse", 32'(n_acc + n_ref), 32'h0);
    check("read target_addr", 32'(last_addr), 32'(a[24:0]));
    check("ext after 4-byte read", 32'(ext_addr_byte), 32'h6c);
    op(8'hb7, 32'h0, 0, 0);
    check("mode after enter", 32'(current_addr_mode), 32'h1);
    set_ext(8'h00);
    a = {8'ha7, 24'($urandom)};
    write_op(8'h20, a, 4, 1'b1, a[24:0]);
    check("ext in 4-byte mode", 32'(ext_addr_byte), 32'ha7);
    hw_reset_pin_n = 1'b0;
    step(4);
    hw_reset_pin_n = 1'b1;
    step(6);
    check("ext after pin reset", 32'(ext_addr_byte), 32'h0);
    check("mode after pin reset", 32'(current_addr_mode), 32'h0);
    pum   = 1'b1;
    reset = 1'b1;
    step(10);
    reset = 1'b0;
    step(6);
    check("mode with pum set", 32'(current_addr_mode), 32'h1);
    a = {8'h01, 24'($urandom)};
    write_op(8'hd8, a, 4, 1'b1, a[24:0]);
    end_of_test();
  end

endmodule

// ===== tb/spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_di
);

  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_di   = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  // Mode 0 host: the clock rests low outside frames and data moves only while it is low
  task automatic frame(input logic [7:0] opc, input logic [31:0] addr, input int nab, input int extra);
    logic [63:0] bits;
    int          n;
    bits     = {opc, (nab == 4) ? addr : {addr[23:0], 8'h00}, 24'h000000};
    n        = 8 + 8 * nab + extra;
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_di = (i < 8 + 8 * nab) ? bits[63 - i] : 1'($urandom);
      #32 spi_sclk = 1'b1;
      #32 spi_sclk = 1'b0;
    end
    #32 spi_cs_n = 1'b1;
    // A released data line must not keep showing the last bit
    spi_di = ~spi_di;
    #64;
  endtask

endmodule

// ===== verilog/flash_protect_and_ext_address.sv
`timescale 1ns/1ps
`include "flash_protect_params.svh"

// Function
// - An erase or program whose target touches a protected part is dropped and the array is left untouched.
// - With complement set and a nonzero code, everything except the matching top (or bottom, by top/bottom) fraction is protected.
// - With complement set, code zero protects all and codes with bit 3 plus bit 2 or bit 1 protect nothing.
// - Lock bits decide acceptance only while the scheme selector is one and are ignored otherwise.
// - After power-up every lock bit is one, so the whole array is locked.
// - A volatile extended-address byte supplies address bit 24 from its bit 0 and is used only in 3-byte mode.
// - In 3-byte mode extended bit 24 picks the lower or upper 128Mb half.
// - After the power-up mode bit is one or enter-4-byte is received, four address bytes are taken and the byte is ignored.
// - Any instruction with a 4-byte address overwrites the extended byte with its top address byte.
// - The extended byte clears to zero at power-up and after software or hardware reset.
// - Scheme zero derives protection from complement, top/bottom and code; scheme one uses the locks.
// - Every lock bit is set to one again after any reset.
// - The power-up mode bit chooses 3-byte or 4-byte mode at power-on or reset.
module flash_protect_and_ext_address (
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire logic                          spi_sclk,
  input  wire logic                          spi_cs_n,
  input  wire logic                          spi_di,
  input  wire logic                          hw_reset_pin_n,
  input  wire logic                          soft_reset_req,
  input  wire logic                          protect_scheme_select,
  input  wire logic                          protect_complement,
  input  wire logic                          top_bottom_select,
  input  wire logic                          block_protect_bit3,
  input  wire logic                          block_protect_bit2,
  input  wire logic                          block_protect_bit1,
  input  wire logic                          block_protect_bit0,
  input  wire logic                          power_up_addr_mode,
  input  wire logic                          ext_addr_wr_en,
  input  wire logic [7:0]                    ext_addr_wr_data,
  input  wire logic                          lock_wr_en,
  input  wire flash_protect_pkg::block_idx_type lock_wr_block,
  input  wire logic                          lock_wr_value,
  input  wire logic                          lock_all_en,
  input  wire logic                          lock_all_value,
  output logic                               current_addr_mode,
  output logic [7:0]                         ext_addr_byte,
  output logic                               addr_valid,
  output logic [24:0]                        target_addr,
  output logic [7:0]                         target_opcode,
  output logic                               op_accept,
  output logic                               op_refuse
);
  import flash_protect_pkg::*;

  logic [2:0]    pin_meta_reg;
  logic [2:0]    pin_sync_reg;
  logic          hw_meta_reg;
  logic          hw_sync_reg;
  logic          sclk_prev_reg;
  logic          cs_prev_reg;
  logic          sclk_s;
  logic          cs_s;
  logic          di_s;
  logic          sclk_rise;
  logic          cs_rise;
  logic          init;
  logic [5:0]    bit_cnt_reg;
  logic [5:0]    bit_cnt_next;
  logic [2:0]    bit_phase_reg;
  logic [31:0]   shift_reg;
  logic [31:0]   shift_next;
  logic [7:0]    opcode_reg;
  logic          four_byte_reg;
  logic          addr_have_reg;
  logic          addr_done;
  op_class_type  op_class;
  logic          decide;
  logic          enter4_done;
  logic [3:0]    bp_code;
  logic [9:0]    region_blocks;
  logic [9:0]    blk_wide;
  logic          in_region;
  logic          sch0_blk_prot;
  logic          sch0_any_prot;
  logic          lock_bit;
  logic          lock_any;
  logic          target_prot;
  block_idx_type tgt_block;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_meta_reg <= `FP_PINS_RESET;
      pin_sync_reg <= `FP_PINS_RESET;
      hw_meta_reg  <= 1'b1;
      hw_sync_reg  <= 1'b1;
    end else begin
      pin_meta_reg <= {spi_di, spi_cs_n, spi_sclk};
      pin_sync_reg <= pin_meta_reg;
      hw_meta_reg  <= hw_reset_pin_n;
      hw_sync_reg  <= hw_meta_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
      cs_prev_reg   <= cs_s;
    end
  end

  assign sclk_s    = pin_sync_reg[0];
  assign cs_s      = pin_sync_reg[1];
  assign di_s      = pin_sync_reg[2];
  assign sclk_rise = sclk_s & ~sclk_prev_reg;
  assign cs_rise   = cs_s & ~cs_prev_reg;
  // Hardware reset holds the state cleared for as long as the pin is low
  assign init      = reset | soft_reset_req | ~hw_sync_reg;

  // ----------------------------------------------------------------
  // Instruction classification
  // ----------------------------------------------------------------
  function automatic logic is_4b_opcode(input logic [7:0] opc);
    is_4b_opcode = (opc == `FP_OPC_READ4) || (opc == `FP_OPC_FREAD4) || (opc == `FP_OPC_PROG4) ||
                   (opc == `FP_OPC_SE4) || (opc == `FP_OPC_BE64_4);
  endfunction

  always_comb begin
    unique case (opcode_reg)
      `FP_OPC_READ, `FP_OPC_READ4, `FP_OPC_FREAD, `FP_OPC_FREAD4: op_class = op_read;
      `FP_OPC_PROG, `FP_OPC_PROG4, `FP_OPC_SE, `FP_OPC_SE4,
      `FP_OPC_BE32, `FP_OPC_BE64, `FP_OPC_BE64_4:                 op_class = op_write;
      `FP_OPC_CE_A, `FP_OPC_CE_B:                                 op_class = op_chip;
      default:                                                    op_class = op_none;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------
  assign shift_next   = {shift_reg[30:0], di_s};
  assign bit_cnt_next = (bit_cnt_reg == `FP_BITS_MAX) ? bit_cnt_reg : bit_cnt_reg + 6'd1;

  always_ff @(posedge core_clk) begin
    if (init || cs_s) begin
      bit_cnt_reg   <= 6'd0;
      bit_phase_reg <= 3'd0;
      shift_reg     <= 32'h0000_0000;
      opcode_reg    <= 8'h00;
      four_byte_reg <= 1'b0;
    end else if (sclk_rise) begin
      bit_cnt_reg   <= bit_cnt_next;
      bit_phase_reg <= bit_phase_reg + 3'd1;
      shift_reg     <= shift_next;
      if (bit_cnt_next == `FP_BITS_OPCODE) begin
        opcode_reg    <= shift_next[7:0];
        four_byte_reg <= is_4b_opcode(shift_next[7:0]) | current_addr_mode;
      end
    end
  end

  assign addr_done = sclk_rise && !cs_s && (op_class != op_none) && (op_class != op_chip) &&
                     (bit_cnt_reg >= `FP_BITS_OPCODE) &&
                     (four_byte_reg ? (bit_cnt_next == `FP_BITS_4B) : (bit_cnt_next == `FP_BITS_3B));

  always_ff @(posedge core_clk) begin
    if (init || cs_s) begin
      addr_have_reg <= 1'b0;
    end else if (addr_done) begin
      addr_have_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Address mode and extended address byte
  // ----------------------------------------------------------------
  assign enter4_done = cs_rise && (bit_cnt_reg == `FP_BITS_OPCODE) && (opcode_reg == `FP_OPC_ENTER4);

  always_ff @(posedge core_clk) begin
    if (init) begin
      current_addr_mode <= power_up_addr_mode;
    end else if (enter4_done) begin
      current_addr_mode <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      ext_addr_byte <= `FP_EXT_RESET;
    end else if (addr_done && four_byte_reg) begin
      ext_addr_byte <= shift_next[31:24];
    end else if (ext_addr_wr_en) begin
      ext_addr_byte <= ext_addr_wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      target_addr   <= 25'h000_0000;
      target_opcode <= 8'h00;
      addr_valid    <= 1'b0;
    end else begin
      addr_valid <= addr_done;
      if (addr_done) begin
        target_opcode <= opcode_reg;
        if (four_byte_reg) begin
          target_addr <= shift_next[24:0];
        end else begin
          target_addr <= {ext_addr_byte[0], shift_next[23:0]};
        end
      end else if (cs_rise && op_class == op_chip) begin
        target_opcode <= opcode_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Protection decode
  // ----------------------------------------------------------------
  assign bp_code   = {block_protect_bit3, block_protect_bit2, block_protect_bit1, block_protect_bit0};
  assign tgt_block = target_addr[`FP_BLOCK_MSB:`FP_BLOCK_LSB];
  assign blk_wide  = {1'b0, tgt_block};

  // Codes above nine all cover the full die, so one region size serves both tables
  always_comb begin
    if (bp_code == 4'h0) begin
      region_blocks = 10'd0;
    end else if (bp_code <= 4'h9) begin
      region_blocks = 10'd1 << (bp_code - 4'h1);
    end else begin
      region_blocks = `FP_NUM_BLOCKS;
    end
  end

  assign in_region     = top_bottom_select ? (blk_wide < region_blocks) :
                                             (blk_wide >= (`FP_NUM_BLOCKS - region_blocks));
  assign sch0_blk_prot = protect_complement ^ in_region;
  assign sch0_any_prot = protect_complement ? (region_blocks != `FP_NUM_BLOCKS) : (region_blocks != 10'd0);

  lock_bank u_lock_bank (
    .core_clk   (core_clk),
    .init       (init),
    .wr_en      (lock_wr_en),
    .wr_block   (lock_wr_block),
    .wr_value   (lock_wr_value),
    .all_en     (lock_all_en),
    .all_value  (lock_all_value),
    .rd_block   (tgt_block),
    .rd_value   (lock_bit),
    .any_locked (lock_any)
  );

  always_comb begin
    if (op_class == op_chip) begin
      target_prot = protect_scheme_select ? lock_any : sch0_any_prot;
    end else begin
      target_prot = protect_scheme_select ? lock_bit : sch0_blk_prot;
    end
  end

  // Write-type frames not ending on a byte boundary are dropped without any answer
  assign decide = cs_rise && (bit_phase_reg == 3'd0) &&
                  (((op_class == op_write) && addr_have_reg) ||
                   ((op_class == op_chip) && (bit_cnt_reg == `FP_BITS_OPCODE)));

  always_ff @(posedge core_clk) begin
    if (init) begin
      op_accept <= 1'b0;
      op_refuse <= 1'b0;
    end else begin
      op_accept <= decide && !target_prot;
      op_refuse <= decide && target_prot;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  refuse_on_prot_a: assert property (@(posedge core_clk) disable iff (init)
    decide |=> (op_refuse == $past(target_prot)) && (op_accept != op_refuse))
    else $error("protected write not refused");

  compl_top_keep_a: assert property (@(posedge core_clk) disable iff (init)
    (decide && !protect_scheme_select && protect_complement && !top_bottom_select &&
     bp_code == 4'h1 && op_class == op_write && tgt_block == 9'd511) ##1 !init |-> op_accept)
    else $error("top block not free under complement");

  compl_code_zero_a: assert property (@(posedge core_clk) disable iff (init)
    (decide && !protect_scheme_select && protect_complement && bp_code == 4'h0) |=> op_refuse)
    else $error("complement code zero must protect all");

  lock_ignored_a: assert property (@(posedge core_clk) disable iff (init)
    (decide && !protect_scheme_select && !protect_complement && bp_code == 4'h0) |=> op_accept)
    else $error("locks used under scheme zero");

  lock_reset_a: assert property (@(posedge core_clk)
    init ##1 !init && !lock_all_en && !lock_wr_en |-> lock_any && lock_bit)
    else $error("locks not set after reset");

  upper_half_a: assert property (@(posedge core_clk) disable iff (init)
    (addr_done && !four_byte_reg) |=> addr_valid && (target_addr[24] == $past(ext_addr_byte[0])))
    else $error("3-byte address ignores extended bit");

  enter_four_a: assert property (@(posedge core_clk) disable iff (init)
    enter4_done |=> current_addr_mode [*3])
    else $error("enter 4-byte mode not held");

  ext_capture_a: assert property (@(posedge core_clk) disable iff (init)
    (addr_done && four_byte_reg) |=> (ext_addr_byte == $past(shift_next[31:24])))
    else $error("extended byte not replaced");

  ext_clear_a: assert property (@(posedge core_clk)
    init |=> (ext_addr_byte == `FP_EXT_RESET))
    else $error("extended byte not cleared");

  lock_scheme_a: assert property (@(posedge core_clk) disable iff (init)
    (decide && protect_scheme_select && op_class == op_write && !lock_bit) |=> op_accept)
    else $error("unlocked block refused");

  mode_init_a: assert property (@(posedge core_clk)
    init |=> (current_addr_mode == $past(power_up_addr_mode)))
    else $error("power-up mode not taken");

  accepted_write_c: cover property (@(posedge core_clk) disable iff (init) op_accept);
  refused_write_c:  cover property (@(posedge core_clk) disable iff (init) op_refuse);
  four_byte_c:      cover property (@(posedge core_clk) disable iff (init) addr_done && four_byte_reg);
  enter_mode_c:     cover property (@(posedge core_clk) disable iff (init) enter4_done);

endmodule

// ===== verilog/flash_protect_params.svh
`ifndef FLASH_PROTECT_PARAMS_SVH
`define FLASH_PROTECT_PARAMS_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define FP_NUM_BLOCKS     10'd512
`define FP_BLOCK_W        9
`define FP_ADDR_W         25
`define FP_BLOCK_LSB      16
`define FP_BLOCK_MSB      24

// ----------------------------------------------------------------
// Serial framing counts
// ----------------------------------------------------------------
`define FP_BITS_OPCODE    6'd8
`define FP_BITS_3B        6'd32
`define FP_BITS_4B        6'd40
`define FP_BITS_MAX       6'd63

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FP_EXT_RESET      8'h00
`define FP_LOCK_RESET     1'b1
`define FP_PINS_RESET     3'h2

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define FP_OPC_READ       8'h03
`define FP_OPC_READ4      8'h13
`define FP_OPC_FREAD      8'h0b
`define FP_OPC_FREAD4     8'h0c
`define FP_OPC_PROG       8'h02
`define FP_OPC_PROG4      8'h12
`define FP_OPC_SE         8'h20
`define FP_OPC_SE4        8'h21
`define FP_OPC_BE32       8'h52
`define FP_OPC_BE64       8'hd8
`define FP_OPC_BE64_4     8'hdc
`define FP_OPC_CE_A       8'hc7
`define FP_OPC_CE_B       8'h60
`define FP_OPC_ENTER4     8'hb7

`endif

// ===== verilog/flash_protect_pkg.sv
package flash_protect_pkg;

  typedef logic [8:0] block_idx_type;

  typedef enum logic [1:0] {
    op_none,
    op_read,
    op_write,
    op_chip
  } op_class_type;

endpackage

// ===== verilog/lock_bank.sv
`timescale 1ns/1ps
`include "flash_protect_params.svh"

module lock_bank (
  input  wire logic                          core_clk,
  input  wire logic                          init,
  input  wire logic                          wr_en,
  input  wire flash_protect_pkg::block_idx_type wr_block,
  input  wire logic                          wr_value,
  input  wire logic                          all_en,
  input  wire logic                          all_value,
  input  wire flash_protect_pkg::block_idx_type rd_block,
  output logic                               rd_value,
  output logic                               any_locked
);
  import flash_protect_pkg::*;

  logic [511:0] lock_bits_reg;

  // ----------------------------------------------------------------
  // Lock storage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (init) begin
      lock_bits_reg <= {512{`FP_LOCK_RESET}};
    end else if (all_en) begin
      lock_bits_reg <= {512{all_value}};
    end else if (wr_en) begin
      lock_bits_reg[wr_block] <= wr_value;
    end
  end

  assign rd_value   = lock_bits_reg[rd_block];
  assign any_locked = |lock_bits_reg;

endmodule
